// *** exc_vec_pkg.sv ***
// Package for the exception vector address and fetch unit.
// Assumes a 16-bit external word bus with 24-bit byte addresses.
package exc_vec_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int VEC_COUNT = 256;
  localparam int TABLE_BYTES = 1024;
  localparam logic [23:0] BASE_RESET = 24'h000000;
  localparam logic [23:0] RESET_VEC_ADDR = 24'h000000;
  localparam logic [23:0] RESET_LAST_ADDR = 24'h000006;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_FIRST = 8'h20;
  localparam logic [7:0] VEC_USER_FIRST = 8'h40;
  localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUP_PROG = 3'h6;
  localparam logic [2:0] SPACE_CPU = 3'h7;
  localparam logic [1:0] SCALE_SHIFT = 2'h2;

  // Bus request carried to the external bus unit
  typedef struct packed {
    logic valid;
    logic [2:0] space;
    logic [23:0] addr;
  } bus_req_t;

  // Bus response from the external bus unit
  typedef struct packed {
    logic ack;
    logic autovec;
    logic berr;
    logic [15:0] data;
  } bus_rsp_t;
endpackage : exc_vec_pkg

// *** exception_vector_fetch.sv ***
// Exception vector address generation and reset vector fetch.
// Assumes an external bus unit that runs one word access per request and
// answers with ack, autovec or berr in a later cycle; sequencer is on clk_i.
`timescale 1ns/1ps
`default_nettype none

module exception_vector_fetch #(
  parameter int VEC_N = 256 // Number of vectors
) (
  input wire logic clk_i, // 50 MHz core clock
  input wire logic reset_i, // Async reset, active high
  input wire logic base_wr_i, // Control register move write strobe
  input wire logic [23:0] base_wdata_i, // New table base
  input wire logic exc_req_i, // Exception request from sequencer
  input wire logic [7:0] exc_vec_i, // Vector number of exception
  input wire logic iack_req_i, // Interrupt acknowledge request
  input wire logic [2:0] irq_level_i, // Level being acknowledged
  input wire exc_vec_pkg::bus_rsp_t rsp_i, // Bus response
  output var exc_vec_pkg::bus_req_t req_o, // Bus request
  output logic busy_o, // Sequence in progress
  output logic [23:0] base_o, // Current table base
  output logic [31:0] sp_o, // Loaded stack pointer
  output logic [31:0] pc_o, // Loaded handler or reset address
  output logic [7:0] vec_o, // Vector number in use
  output logic done_o // Pulse: pc_o valid
);
  // Elaboration check: vector numbers are eight bits wide
  if (VEC_N != exc_vec_pkg::VEC_COUNT) begin : g_bad_vec_n
    $error("VEC_N must be 256");
  end

  typedef enum logic [2:0] {
    ST_RESET, ST_IDLE, ST_IACK, ST_HI, ST_LO
  } state_t;

  state_t state_q, state_d;
  logic [23:0] base_q;
  logic [23:0] addr_q, addr_d;
  logic [2:0] space_q, space_d;
  logic [1:0] rcnt_q, rcnt_d;
  logic [31:0] sp_q, sp_d, pc_q, pc_d;
  logic [7:0] vec_q, vec_d;
  logic done_q, done_d;
  logic valid_q, valid_d;

  // Vector selection and address forming
  wire logic [7:0] auto_vec = exc_vec_pkg::VEC_AUTO_BASE + {5'h00, irq_level_i};
  wire logic [7:0] iack_vec = rsp_i.autovec ? auto_vec :
                              rsp_i.berr ? exc_vec_pkg::VEC_SPURIOUS :
                              rsp_i.data[7:0];
  wire logic [23:0] vec_off = {14'h0000, exc_vec_i, 2'h0};
  wire logic [23:0] iack_off = {14'h0000, iack_vec, 2'h0};
  wire logic [23:0] exc_addr = base_q + vec_off;
  wire logic [23:0] iack_addr = base_q + iack_off;
  wire logic [23:0] next_word = addr_q + 24'h000002;
  wire logic resp = rsp_i.ack | rsp_i.berr | rsp_i.autovec;

  // Table base: cleared by reset, written only by the move port
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      base_q <= exc_vec_pkg::BASE_RESET;
    end else if (base_wr_i) begin
      base_q <= base_wdata_i;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    space_d = space_q;
    rcnt_d = rcnt_q;
    sp_d = sp_q;
    pc_d = pc_q;
    vec_d = vec_q;
    done_d = 1'b0;
    valid_d = valid_q;
    case (state_q)
      ST_RESET: begin
        // Four words: SP hi, SP lo, PC hi, PC lo
        if (!valid_q) begin
          valid_d = 1'b1;
          addr_d = exc_vec_pkg::RESET_VEC_ADDR;
          space_d = exc_vec_pkg::SPACE_SUP_PROG;
          vec_d = 8'h00;
        end else if (rsp_i.ack) begin
          case (rcnt_q)
            2'h0: sp_d = {rsp_i.data, sp_q[15:0]};
            2'h1: sp_d = {sp_q[31:16], rsp_i.data};
            2'h2: pc_d = {rsp_i.data, pc_q[15:0]};
            default: pc_d = {pc_q[31:16], rsp_i.data};
          endcase
          rcnt_d = rcnt_q + 2'h1;
          addr_d = next_word;
          if (rcnt_q == 2'h3) begin
            valid_d = 1'b0;
            done_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (iack_req_i) begin
          valid_d = 1'b1;
          addr_d = {21'h1fffff, irq_level_i};
          space_d = exc_vec_pkg::SPACE_CPU;
          state_d = ST_IACK;
        end else if (exc_req_i) begin
          valid_d = 1'b1;
          addr_d = exc_addr;
          space_d = exc_vec_pkg::SPACE_SUP_DATA;
          vec_d = exc_vec_i;
          state_d = ST_HI;
        end
      end
      ST_IACK: begin
        if (resp) begin
          addr_d = iack_addr;
          space_d = exc_vec_pkg::SPACE_SUP_DATA;
          vec_d = iack_vec;
          state_d = ST_HI;
        end
      end
      ST_HI: begin
        if (rsp_i.ack) begin
          pc_d = {rsp_i.data, pc_q[15:0]};
          addr_d = next_word;
          state_d = ST_LO;
        end
      end
      ST_LO: begin
        if (rsp_i.ack) begin
          pc_d = {pc_q[31:16], rsp_i.data};
          valid_d = 1'b0;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_RESET;
      addr_q <= 24'h000000;
      space_q <= 3'h0;
      rcnt_q <= 2'h0;
      sp_q <= 32'h00000000;
      pc_q <= 32'h00000000;
      vec_q <= 8'h00;
      done_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      space_q <= space_d;
      rcnt_q <= rcnt_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      vec_q <= vec_d;
      done_q <= done_d;
      valid_q <= valid_d;
    end
  end

  // Outputs
  assign req_o = '{valid: valid_q, space: space_q, addr: addr_q};
  assign busy_o = (state_q != ST_IDLE);
  assign base_o = base_q;
  assign sp_o = sp_q;
  assign pc_o = pc_q;
  assign vec_o = vec_q;
  assign done_o = done_q;

  // Checks
  sequence s_word_ack;
    req_o.valid && rsp_i.ack;
  endsequence

  chk_reset_space: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RESET && req_o.valid) |-> req_o.space == exc_vec_pkg::SPACE_SUP_PROG)
    else $error("Reset vector read not in supervisor program space");
  chk_vector_space: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q inside {ST_HI, ST_LO}) |-> req_o.space == exc_vec_pkg::SPACE_SUP_DATA)
    else $error("Vector read not in supervisor data space");
  chk_reset_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RESET && req_o.valid) |->
    req_o.addr == {21'h000000, rcnt_q, 1'b0} && req_o.addr <= exc_vec_pkg::RESET_LAST_ADDR)
    else $error("Reset word address wrong");
  chk_base_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    !base_wr_i |=> base_o == $past(base_o))
    else $error("Base changed without move write");
  chk_base_write: assert property (@(posedge clk_i) disable iff (reset_i)
    base_wr_i |=> base_o == $past(base_wdata_i))
    else $error("Base write lost");
  chk_exc_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IDLE && !iack_req_i && exc_req_i && !base_wr_i) |=>
    req_o.addr == base_o + {14'h0000, $past(exc_vec_i), 2'h0})
    else $error("Vector address wrong");
  chk_auto_vec: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IACK && rsp_i.autovec) |=>
    vec_o == exc_vec_pkg::VEC_AUTO_BASE + {5'h00, $past(irq_level_i)})
    else $error("Autovector number wrong");
  chk_spurious_vec: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IACK && rsp_i.berr && !rsp_i.autovec) |=>
    vec_o == exc_vec_pkg::VEC_SPURIOUS)
    else $error("Bus error did not select spurious vector");
  chk_handler_pc: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_LO) ##0 s_word_ack |=>
    done_o && pc_o[15:0] == $past(rsp_i.data))
    else $error("Handler address not loaded");
  chk_reset_first: assert property (@(posedge clk_i)
    $fell(reset_i) |-> base_o == exc_vec_pkg::BASE_RESET && state_q == ST_RESET)
    else $error("Base not cleared by reset");

  // Steps of the fetches, used by the checks below
  sequence s_reset_word;
    state_q == ST_RESET && req_o.valid && rsp_i.ack;
  endsequence

  sequence s_hi_word;
    state_q == ST_HI && req_o.valid && rsp_i.ack;
  endsequence

  sequence s_iack_end;
    state_q == ST_IACK && (rsp_i.ack || rsp_i.autovec || rsp_i.berr);
  endsequence

  // Reset fetch: each word lands in its own half, in address order
  chk_reset_sp_hi: assert property (@(posedge clk_i) disable iff (reset_i)
    s_reset_word ##0 (rcnt_q == 2'h0) |=> sp_o[31:16] == $past(rsp_i.data))
    else $error("Stack pointer upper word not loaded");
  chk_reset_sp_lo: assert property (@(posedge clk_i) disable iff (reset_i)
    s_reset_word ##0 (rcnt_q == 2'h1) |=> sp_o[15:0] == $past(rsp_i.data))
    else $error("Stack pointer lower word not loaded");
  chk_reset_pc_hi: assert property (@(posedge clk_i) disable iff (reset_i)
    s_reset_word ##0 (rcnt_q == 2'h2) |=> pc_o[31:16] == $past(rsp_i.data))
    else $error("Program counter upper word not loaded");
  chk_reset_end: assert property (@(posedge clk_i) disable iff (reset_i)
    s_reset_word ##0 (rcnt_q == 2'h3) |=>
    done_o && !req_o.valid && state_q == ST_IDLE && pc_o[15:0] == $past(rsp_i.data))
    else $error("Reset fetch did not end after the fourth word");
  chk_reset_vec_num: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RESET && req_o.valid) |-> vec_o == 8'h00)
    else $error("Reset fetch not reported as vector zero");
  chk_sp_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q != ST_RESET) |=> $stable(sp_o))
    else $error("Stack pointer changed outside the reset fetch");

  // Interrupt acknowledge: cpu space cycle, then a data space vector read
  chk_iack_space: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IACK) |-> req_o.valid && req_o.space == exc_vec_pkg::SPACE_CPU)
    else $error("Acknowledge cycle not in cpu space");
  chk_iack_data_vec: assert property (@(posedge clk_i) disable iff (reset_i)
    s_iack_end ##0 (!rsp_i.autovec && !rsp_i.berr) |=> vec_o == $past(rsp_i.data[7:0]))
    else $error("Device vector not taken");
  chk_auto_range: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IACK && rsp_i.autovec && irq_level_i != 3'h0) |=>
    vec_o inside {[8'h19:8'h1f]})
    else $error("Autovector outside the level range");
  chk_iack_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    s_iack_end ##0 !base_wr_i |=> req_o.valid &&
    req_o.space == exc_vec_pkg::SPACE_SUP_DATA && req_o.addr == base_o + {14'h0000, vec_o, 2'h0})
    else $error("Acknowledged vector address wrong");

  // Handler fetch: upper word first, lower word at the next address
  chk_exc_vec_num: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IDLE && !iack_req_i && exc_req_i) |=>
    state_q == ST_HI && vec_o == $past(exc_vec_i))
    else $error("Exception vector number not taken");
  chk_lo_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    s_hi_word |=> state_q == ST_LO && pc_o[31:16] == $past(rsp_i.data) &&
    req_o.addr == $past(req_o.addr) + 24'h000002)
    else $error("Lower handler word not requested next");
  chk_vec_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_HI) |=> $stable(vec_o))
    else $error("Vector number changed during the fetch");
  chk_idle_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_IDLE) |-> !req_o.valid)
    else $error("Bus request while idle");
  chk_done_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
    done_o |=> !done_o)
    else $error("Done longer than one cycle");
  chk_done_cause: assert property (@(posedge clk_i) disable iff (reset_i)
    done_o |-> $past(state_q) inside {ST_RESET, ST_LO})
    else $error("Done without a finished fetch");
endmodule : exception_vector_fetch

`default_nettype wire

// *** mem_model.sv ***
// Partner model: boot memory and interrupting device on the unit's bus.
// Assumes one request at a time, answered after lat_i wait cycles.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk_i, // Core clock
  input wire logic reset_i, // Async reset
  input wire exc_vec_pkg::bus_req_t req_i, // Request from the unit
  input wire logic [1:0] mode_i, // Iack answer: 0 vector, 1 auto, 2 error
  input wire logic [7:0] dvec_i, // Vector given by the device
  input wire logic [1:0] lat_i, // Wait cycles before an answer
  output var exc_vec_pkg::bus_rsp_t rsp_o // Response to the unit
);
  logic [1:0] cnt_q;
  logic answered;
  assign answered = rsp_o.ack | rsp_o.autovec | rsp_o.berr;
  // Answer after the latency; idle data lines toggle so stale data never looks valid
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_o <= '0;
      cnt_q <= 2'h0;
    end else begin
      rsp_o <= {3'h0, ~rsp_o.data};
      if (req_i.valid && !answered) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == lat_i) begin
          cnt_q <= 2'h0;
          if (req_i.space == exc_vec_pkg::SPACE_CPU) begin
            rsp_o <= {mode_i == 2'h0, mode_i == 2'h1, mode_i == 2'h2, 8'h00, dvec_i};
          end else begin
            rsp_o <= {3'h4, req_i.addr[15:0] ^ 16'h5a3c};
          end
        end
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the exception vector unit with its bus partner.
// Assumes the partner stores word value address xor 16'h5a3c everywhere.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic reset_i, base_wr_i, exc_req_i, iack_req_i, busy_o, done_o;
  logic [23:0] base_wdata_i, base_o, base;
  logic [7:0] exc_vec_i, vec_o, dvec, v8;
  logic [2:0] irq_level_i;
  logic [1:0] mode, lat;
  logic [31:0] sp_o, pc_o;
  exc_vec_pkg::bus_req_t req_o;
  exc_vec_pkg::bus_rsp_t rsp_i;
  logic [71:0] notes[$];
  logic [7:0] vlist[6] = '{8'h02, 8'h0f, 8'h20, 8'h2f, 8'h40, 8'hff};
  int fails = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  exception_vector_fetch uut (.clk_i(clk_i), .reset_i(reset_i), .base_wr_i(base_wr_i),
    .base_wdata_i(base_wdata_i), .exc_req_i(exc_req_i), .exc_vec_i(exc_vec_i),
    .iack_req_i(iack_req_i), .irq_level_i(irq_level_i), .rsp_i(rsp_i), .req_o(req_o),
    .busy_o(busy_o), .base_o(base_o), .sp_o(sp_o), .pc_o(pc_o), .vec_o(vec_o), .done_o(done_o));
  mem_model far (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_o), .mode_i(mode),
    .dvec_i(dvec), .lat_i(lat), .rsp_o(rsp_i));
  // Long word as the partner stores it, upper word first
  function automatic logic [31:0] lw(input logic [23:0] a);
    return {a[15:0] ^ 16'h5a3c, (a[15:0] + 16'h0002) ^ 16'h5a3c};
  endfunction : lw
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (busy_o !== 1'b0) begin
      fails++;
      stop_test();
    end
  endtask : wait_idle
  // One exception or acknowledge; ev is the vector number the unit must use
  task run(input logic ia, input logic [7:0] v, input logic [2:0] lv, input logic [1:0] md,
           input logic [7:0] ev);
    exc_req_i = !ia;
    iack_req_i = ia;
    exc_vec_i = v;
    dvec = v;
    irq_level_i = lv;
    mode = md;
    lat = 2'($urandom);
    notes.push_back({lw(24'h0), ev, lw(base + {14'h0, ev, 2'h0})});
    @(negedge clk_i);
    exc_req_i = 1'b0;
    iack_req_i = 1'b0;
    if (!ia) check(72'(req_o), {44'h0, 1'b1, exc_vec_pkg::SPACE_SUP_DATA, base + {14'h0, ev, 2'h0}});
    else check(72'(req_o), {44'h0, 1'b1, exc_vec_pkg::SPACE_CPU, 21'h1fffff, lv});
    check(72'(busy_o), 72'h1);
    wait_idle();
  endtask : run
  // Result watcher: each completion takes the oldest note
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (notes.size() == 0) check(72'h1, 72'h0);
      else check({sp_o, vec_o, pc_o}, notes.pop_front());
    end
  end
  initial begin
    {reset_i, base_wr_i, exc_req_i, iack_req_i} = 4'h8;
    {base_wdata_i, exc_vec_i, irq_level_i, mode, dvec, lat, base, v8} = '0;
    void'($urandom(32'h0498));
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    // Second pass starts from a reset applied while the unit is idle, with the table base moved
    for (int r = 0; r < 2; r++) begin
      reset_i = 1'b0;
      notes.push_back({lw(24'h0), 8'h00, lw(24'h4)});
      check(72'(base_o), 72'h0);
      @(negedge clk_i);
      check(72'(req_o), {44'h0, 1'b1, exc_vec_pkg::SPACE_SUP_PROG, 24'h0});
      wait_idle();
      $display("test reset fetch done");
      for (int i = 0; i < 7; i++) begin
        base_wdata_i = 24'($urandom);
        base_wr_i = 1'b1;
        @(negedge clk_i);
        base_wr_i = 1'b0;
        base = base_wdata_i;
        check(72'(base_o), 72'(base));
        v8 = (i < 6) ? vlist[i] : (8'h40 | 8'($urandom));
        run(1'b0, v8, 3'h0, 2'h0, v8);
      end
      $display("test exceptions done");
      for (int l = 1; l < 8; l++) begin
        run(1'b1, 8'h00, 3'(l), 2'h1, exc_vec_pkg::VEC_AUTO_BASE + 8'(l));
        v8 = 8'h40 | 8'($urandom);
        run(1'b1, v8, 3'(l), 2'h0, v8);
        run(1'b1, 8'h00, 3'(l), 2'h2, exc_vec_pkg::VEC_SPURIOUS);
      end
      $display("test interrupt acknowledge done");
      @(negedge clk_i);
      reset_i = 1'b1;
      repeat (3) @(negedge clk_i);
    end
    repeat (4) @(negedge clk_i);
    check(72'(notes.size()), 72'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
